// ===== hw/ext_bus_port_pkg.sv
// Shared constants and carrier types for the external bus pin ports.
// Assumes a single 20 MHz clock domain and a plain strobe-driven register port.
package ext_bus_port_pkg;

   // Register bus geometry.
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 8;

   // Register addresses.
   localparam logic [ADDR_W-1:0] HIGH_ADDR_DATA_ADDR   = 32'hFFFF_F006;
   localparam logic [ADDR_W-1:0] HIGH_ADDR_DIR_ADDR    = 32'hFFFF_F026;
   localparam logic [ADDR_W-1:0] HIGH_ADDR_FSEL_ADDR   = 32'hFFFF_F046;
   localparam logic [ADDR_W-1:0] STROBE_FSEL_ADDR      = 32'hFFFF_F04A;

   // Reset values.
   localparam logic [DATA_W-1:0] STROBE_FSEL_RESET     = 8'h00;
   localparam logic [DATA_W-1:0] HIGH_ADDR_FSEL_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] HIGH_ADDR_DIR_RESET   = 8'hFF;
   localparam logic [DATA_W-1:0] HIGH_ADDR_DATA_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] READ_NONE             = 8'h00;
   localparam logic [DATA_W-1:0] ALL_ONES              = 8'hFF;

   // Field positions in the strobe function-select register.
   localparam int unsigned LATCH_STROBE_BIT = 6;
   localparam int unsigned READ_STROBE_BIT  = 4;
   localparam int unsigned UPPER_STORE_BIT  = 1;
   localparam int unsigned LOWER_STORE_BIT  = 0;
   localparam logic [DATA_W-1:0] STROBE_FSEL_MASK = 8'h53;

   // Direction encoding.
   localparam logic DIR_OUTPUT = 1'b0;
   localparam logic DIR_INPUT  = 1'b1;

   // Upper address pins start at this address bit.
   localparam int unsigned HIGH_ADDR_BASE_BIT = 16;

   // Number of strobe-capable pins.
   localparam int unsigned STROBE_PINS = 4;

   // One register access from software.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] bit_mask;
      logic              wr;
      logic              rd;
   } reg_req_t;

   // Strobes from the bus controller, in pin order 3..0 = latch, read, upper, lower.
   typedef struct packed {
      logic latch_strobe;
      logic read_strobe;
      logic upper_store;
      logic lower_store;
   } bus_strobe_t;

endpackage : ext_bus_port_pkg

// ===== hw/external_bus_pin_ports.sv
// Pin multiplexing for the bus-strobe pins and the upper address port.
// Assumes bus controller signals and the strobe port's own I/O controls arrive on core_clk_i;
// pin inputs arrive asynchronously and are synchronised here.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps

module external_bus_pin_ports #(
   parameter int unsigned HIGH_PINS = 8
) (
   // Clock and reset.
   input  wire logic                                    core_clk_i,
   input  wire logic                                    reset_i,
   // Register port.
   input  wire ext_bus_port_pkg::reg_req_t              reg_req_i,
   output logic [ext_bus_port_pkg::DATA_W-1:0]          rd_data_o,
   // Bus controller signals.
   input  wire logic [7:0]                              address_bus_high_i,
   input  wire ext_bus_port_pkg::bus_strobe_t           bus_strobe_i,
   // Strobe port I/O controls from the neighbouring port logic.
   input  wire ext_bus_port_pkg::bus_strobe_t           strobe_port_data_i,
   input  wire ext_bus_port_pkg::bus_strobe_t           strobe_port_dir_i,
   // Strobe pins.
   output ext_bus_port_pkg::bus_strobe_t                strobe_pin_o,
   output ext_bus_port_pkg::bus_strobe_t                strobe_pin_oe_n_o,
   output ext_bus_port_pkg::bus_strobe_t                strobe_pin_alt_o,
   // Upper address pins.
   input  wire logic [7:0]                              high_pin_i,
   output logic [7:0]                                   high_pin_o,
   output logic [7:0]                                   high_pin_oe_n_o
);

   localparam int unsigned W = ext_bus_port_pkg::DATA_W;

   // Pins that exist on this variant; built bit by bit so that eight pins need no wider shift.
   function automatic logic [W-1:0] impl_mask_of(input int unsigned pins);
      impl_mask_of = '0;
      for (int unsigned i = 0; i < W; i++) begin
         if (i < pins) begin
            impl_mask_of[i] = 1'b1;
         end
      end
   endfunction : impl_mask_of

   localparam logic [W-1:0] IMPL_MASK = impl_mask_of(HIGH_PINS);

   // Registers.
   logic [W-1:0] strobe_fsel_q;
   logic [W-1:0] strobe_fsel_d;
   logic [W-1:0] high_fsel_q;
   logic [W-1:0] high_fsel_d;
   logic [W-1:0] high_dir_q;
   logic [W-1:0] high_dir_d;
   logic [W-1:0] high_data_q;
   logic [W-1:0] high_data_d;
   logic [W-1:0] rd_data_q;
   logic [W-1:0] rd_data_d;
   logic [W-1:0] data_view;

   // Input synchroniser.
   logic [W-1:0] sync1_q;
   logic [W-1:0] sync2_q;
   logic [W-1:0] sync3_q;
   logic [W-1:0] pin_level_q;
   logic [W-1:0] pin_level_d;

   // Pin outputs.
   logic [W-1:0]                  high_out_q;
   logic [W-1:0]                  high_out_d;
   logic [W-1:0]                  high_oen_q;
   logic [W-1:0]                  high_oen_d;
   ext_bus_port_pkg::bus_strobe_t strobe_out_q;
   ext_bus_port_pkg::bus_strobe_t strobe_out_d;
   ext_bus_port_pkg::bus_strobe_t strobe_oen_q;
   ext_bus_port_pkg::bus_strobe_t strobe_oen_d;
   ext_bus_port_pkg::bus_strobe_t strobe_alt_q;
   ext_bus_port_pkg::bus_strobe_t strobe_alt_d;

   // Decoded accesses.
   logic hit_strobe_fsel;
   logic hit_high_fsel;
   logic hit_high_dir;
   logic hit_high_data;

   assign hit_strobe_fsel = (reg_req_i.addr == ext_bus_port_pkg::STROBE_FSEL_ADDR);
   assign hit_high_fsel   = (reg_req_i.addr == ext_bus_port_pkg::HIGH_ADDR_FSEL_ADDR);
   assign hit_high_dir    = (reg_req_i.addr == ext_bus_port_pkg::HIGH_ADDR_DIR_ADDR);
   assign hit_high_data   = (reg_req_i.addr == ext_bus_port_pkg::HIGH_ADDR_DATA_ADDR);

   // Accesses qualified by their strobe.
   logic wr_strobe_fsel;
   logic wr_high_fsel;
   logic wr_high_dir;
   logic wr_high_data;
   logic rd_strobe_fsel;
   logic rd_high_fsel;
   logic rd_high_dir;
   logic rd_high_data;

   assign wr_strobe_fsel = reg_req_i.wr & hit_strobe_fsel;
   assign wr_high_fsel   = reg_req_i.wr & hit_high_fsel;
   assign wr_high_dir    = reg_req_i.wr & hit_high_dir;
   assign wr_high_data   = reg_req_i.wr & hit_high_data;
   assign rd_strobe_fsel = reg_req_i.rd & hit_strobe_fsel;
   assign rd_high_fsel   = reg_req_i.rd & hit_high_fsel;
   assign rd_high_dir    = reg_req_i.rd & hit_high_dir;
   assign rd_high_data   = reg_req_i.rd & hit_high_data;

   // Merges a write into a register under the bit mask, so one bit can change alone.
   function automatic logic [W-1:0] merge(input logic [W-1:0] old_v, input logic [W-1:0] new_v,
                                          input logic [W-1:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction : merge

   // Register writes.
   always_comb begin
      strobe_fsel_d = strobe_fsel_q;
      high_fsel_d   = high_fsel_q;
      high_dir_d    = high_dir_q;
      high_data_d   = high_data_q;
      if (wr_strobe_fsel) begin
         strobe_fsel_d = merge(strobe_fsel_q, reg_req_i.wdata, reg_req_i.bit_mask) &
                         ext_bus_port_pkg::STROBE_FSEL_MASK;
      end
      if (wr_high_fsel) begin
         high_fsel_d = merge(high_fsel_q, reg_req_i.wdata, reg_req_i.bit_mask) & IMPL_MASK;
      end
      if (wr_high_dir) begin
         high_dir_d = merge(high_dir_q, reg_req_i.wdata, reg_req_i.bit_mask) | ~IMPL_MASK;
      end
      if (wr_high_data) begin
         // The latch takes the write whatever the direction; input pins are unaffected.
         high_data_d = merge(high_data_q, reg_req_i.wdata, reg_req_i.bit_mask) & IMPL_MASK;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         strobe_fsel_q <= ext_bus_port_pkg::STROBE_FSEL_RESET;
         high_fsel_q   <= ext_bus_port_pkg::HIGH_ADDR_FSEL_RESET;
         high_dir_q    <= ext_bus_port_pkg::HIGH_ADDR_DIR_RESET;
         // Software must not rely on this value.
         high_data_q   <= ext_bus_port_pkg::HIGH_ADDR_DATA_RESET;
      end else begin
         strobe_fsel_q <= strobe_fsel_d;
         high_fsel_q   <= high_fsel_d;
         high_dir_q    <= high_dir_d;
         high_data_q   <= high_data_d;
      end
   end

   // Pin input synchroniser; a new level counts once the second and third stages agree.
   always_comb begin
      pin_level_d = pin_level_q;
      for (int i = 0; i < W; i++) begin
         if (sync2_q[i] == sync3_q[i]) begin
            pin_level_d[i] = sync3_q[i];
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         sync1_q     <= ext_bus_port_pkg::READ_NONE;
         sync2_q     <= ext_bus_port_pkg::READ_NONE;
         sync3_q     <= ext_bus_port_pkg::READ_NONE;
         pin_level_q <= ext_bus_port_pkg::READ_NONE;
      end else begin
         sync1_q     <= high_pin_i & IMPL_MASK;
         sync2_q     <= sync1_q;
         sync3_q     <= sync2_q;
         pin_level_q <= pin_level_d;
      end
   end

   // Data register as software sees it: pin level for input bits, latch for output bits.
   always_comb begin
      data_view = ext_bus_port_pkg::READ_NONE;
      for (int i = 0; i < W; i++) begin
         data_view[i] = (high_dir_q[i] == ext_bus_port_pkg::DIR_INPUT) ?
                        pin_level_q[i] : high_data_q[i];
      end
      data_view = data_view & IMPL_MASK;
   end

   // Read data stands only in the cycle after the read strobe.
   always_comb begin
      rd_data_d = ext_bus_port_pkg::READ_NONE;
      if (rd_strobe_fsel) begin
         rd_data_d = strobe_fsel_q & ext_bus_port_pkg::STROBE_FSEL_MASK;
      end else if (rd_high_fsel) begin
         rd_data_d = high_fsel_q;
      end else if (rd_high_dir) begin
         rd_data_d = high_dir_q & IMPL_MASK;
      end else if (rd_high_data) begin
         rd_data_d = data_view;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rd_data_q <= ext_bus_port_pkg::READ_NONE;
      end else begin
         rd_data_q <= rd_data_d;
      end
   end

   // Pin drive, computed from the next register values so a write reaches the pin on the same edge.
   // Missing pins stay undriven: their select is masked off and their direction is forced to input.
   pin_drive_sel #(
      .W(W)
   ) i_high_drive (
      .alt_sel_i    (high_fsel_d),
      .dir_i        (high_dir_d),
      .alt_level_i  (address_bus_high_i),
      .port_level_i (high_data_d),
      .level_o      (high_out_d),
      .oe_n_o       (high_oen_d)
   );

   // Alternate function of each strobe pin, in pin order.
   always_comb begin
      strobe_alt_d.latch_strobe = strobe_fsel_d[ext_bus_port_pkg::LATCH_STROBE_BIT];
      strobe_alt_d.read_strobe  = strobe_fsel_d[ext_bus_port_pkg::READ_STROBE_BIT];
      strobe_alt_d.upper_store  = strobe_fsel_d[ext_bus_port_pkg::UPPER_STORE_BIT];
      strobe_alt_d.lower_store  = strobe_fsel_d[ext_bus_port_pkg::LOWER_STORE_BIT];
   end

   pin_drive_sel #(
      .W(ext_bus_port_pkg::STROBE_PINS)
   ) i_strobe_drive (
      .alt_sel_i    (strobe_alt_d),
      .dir_i        (strobe_port_dir_i),
      .alt_level_i  (bus_strobe_i),
      .port_level_i (strobe_port_data_i),
      .level_o      (strobe_out_d),
      .oe_n_o       (strobe_oen_d)
   );

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         high_out_q   <= ext_bus_port_pkg::READ_NONE;
         high_oen_q   <= ext_bus_port_pkg::ALL_ONES;
         strobe_out_q <= '0;
         strobe_oen_q <= '1;
         strobe_alt_q <= '0;
      end else begin
         high_out_q   <= high_out_d;
         high_oen_q   <= high_oen_d;
         strobe_out_q <= strobe_out_d;
         strobe_oen_q <= strobe_oen_d;
         strobe_alt_q <= strobe_alt_d;
      end
   end

   assign rd_data_o         = rd_data_q;
   assign high_pin_o        = high_out_q;
   assign high_pin_oe_n_o   = high_oen_q;
   assign strobe_pin_o      = strobe_out_q;
   assign strobe_pin_oe_n_o = strobe_oen_q;
   assign strobe_pin_alt_o  = strobe_alt_q;

endmodule : external_bus_pin_ports

// Output drive of a row of pins: an alternate function overrides the port latch and direction,
// otherwise a pin is driven from its latch only while its direction bit selects output.
module pin_drive_sel #(
   parameter int unsigned W = 8
) (
   // Selects.
   input  wire logic [W-1:0] alt_sel_i,
   input  wire logic [W-1:0] dir_i,
   // Levels.
   input  wire logic [W-1:0] alt_level_i,
   input  wire logic [W-1:0] port_level_i,
   // Pin drive, before the output flip-flops.
   output logic      [W-1:0] level_o,
   output logic      [W-1:0] oe_n_o
);

   always_comb begin
      level_o = '0;
      oe_n_o  = '1;
      for (int i = 0; i < W; i++) begin
         if (alt_sel_i[i]) begin
            level_o[i] = alt_level_i[i];
            oe_n_o[i]  = 1'b0;
         end else if (dir_i[i] == ext_bus_port_pkg::DIR_OUTPUT) begin
            level_o[i] = port_level_i[i];
            oe_n_o[i]  = 1'b0;
         end
      end
   end

endmodule : pin_drive_sel

// ===== testbench/ext_bus_port_checker.sv
// Concurrent checks on the pin port block, seen only through its top-level ports.
// Assumes one clock domain, synchronous reset and registered pin outputs.
`timescale 1ns/100ps
module ext_bus_port_checker #(
   parameter int unsigned HIGH_PINS = 8
) (
   // Clock and reset.
   input wire logic                             core_clk_i,
   input wire logic                             reset_i,
   // Register port.
   input wire ext_bus_port_pkg::reg_req_t       reg_req_i,
   input wire logic [7:0]                       rd_data_o,
   // Bus side and strobe controls.
   input wire logic [7:0]                       address_bus_high_i,
   input wire ext_bus_port_pkg::bus_strobe_t    bus_strobe_i,
   input wire ext_bus_port_pkg::bus_strobe_t    strobe_port_data_i,
   input wire ext_bus_port_pkg::bus_strobe_t    strobe_port_dir_i,
   // Pins.
   input wire ext_bus_port_pkg::bus_strobe_t    strobe_pin_o,
   input wire ext_bus_port_pkg::bus_strobe_t    strobe_pin_oe_n_o,
   input wire ext_bus_port_pkg::bus_strobe_t    strobe_pin_alt_o,
   input wire logic [7:0]                       high_pin_o,
   input wire logic [7:0]                       high_pin_oe_n_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   localparam logic [7:0] PM = 8'((1 << HIGH_PINS) - 1);
   logic [3:0] alt;
   logic [3:0] oen;
   logic [3:0] spin;
   assign alt  = strobe_pin_alt_o;
   assign oen  = strobe_pin_oe_n_o;
   assign spin = strobe_pin_o;
   sequence s_wr(logic [31:0] a);
      reg_req_i.wr && reg_req_i.addr == a && reg_req_i.bit_mask == 8'hFF;
   endsequence
   chk_read_idle_zero: assert property (!$past(reg_req_i.rd) |-> rd_data_o == 8'h00)
      else $error("read data not zero outside its slot");
   chk_fsel_rsvd_zero: assert property (reg_req_i.rd && reg_req_i.addr == ext_bus_port_pkg::STROBE_FSEL_ADDR
      |=> (rd_data_o & ~ext_bus_port_pkg::STROBE_FSEL_MASK) == 8'h00) else $error("reserved strobe select bit set");
   chk_fsel_alt_map: assert property (s_wr(ext_bus_port_pkg::STROBE_FSEL_ADDR) |=>
      {1'b0, alt[3], 1'b0, alt[2], 2'b00, alt[1:0]} == ($past(reg_req_i.wdata) & ext_bus_port_pkg::STROBE_FSEL_MASK))
      else $error("strobe alternate map wrong");
   chk_strobe_alt_drive: assert property (alt != 4'h0 && !$past(reset_i) |->
      (alt & oen) == 4'h0 && (alt & (spin ^ $past(bus_strobe_i))) == 4'h0) else $error("strobe pin not bus driven");
   chk_strobe_dir_oe: assert property (!$past(reset_i) |-> (~alt & (oen ^ $past(strobe_port_dir_i))) == 4'h0)
      else $error("strobe enable does not follow direction");
   chk_strobe_out_level: assert property (!$past(reset_i) |-> (~alt & ~oen & (spin ^ $past(strobe_port_data_i))) == 4'h0)
      else $error("strobe output level wrong");
   chk_high_alt_drive: assert property (s_wr(ext_bus_port_pkg::HIGH_ADDR_FSEL_ADDR) |=>
      ((high_pin_oe_n_o | (high_pin_o ^ $past(address_bus_high_i))) & $past(reg_req_i.wdata) & PM) == 8'h00)
      else $error("address pin not driven by bus");
   chk_reset_pins_idle: assert property ($fell(reset_i) |-> alt == 4'h0 && high_pin_oe_n_o == 8'hFF)
      else $error("pins not in port mode after reset");
endmodule : ext_bus_port_checker

bind external_bus_pin_ports ext_bus_port_checker #(.HIGH_PINS(HIGH_PINS)) i_chk (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i), .rd_data_o(rd_data_o),
   .address_bus_high_i(address_bus_high_i), .bus_strobe_i(bus_strobe_i), .strobe_port_data_i(strobe_port_data_i),
   .strobe_port_dir_i(strobe_port_dir_i), .strobe_pin_o(strobe_pin_o), .strobe_pin_oe_n_o(strobe_pin_oe_n_o),
   .strobe_pin_alt_o(strobe_pin_alt_o), .high_pin_o(high_pin_o), .high_pin_oe_n_o(high_pin_oe_n_o));

// ===== testbench/high_pin_far_end.sv
// Far end of the upper address pins: resolves each wire from the block and the far driver.
// Assumes no pull resistors, so a wire nobody drives toggles every cycle.
`timescale 1ns/100ps
module high_pin_far_end (
   // Clock.
   input  wire logic       core_clk_i,
   // Block side and far driver.
   input  wire logic [7:0] high_pin_o,
   input  wire logic [7:0] high_pin_oe_n_o,
   input  wire logic [7:0] far_level_i,
   input  wire logic [7:0] far_en_i,
   // Resolved wire.
   output logic [7:0]      high_pin_i
);
   logic [7:0] float_q = 8'h00;
   always_ff @(posedge core_clk_i) begin
      float_q <= ~float_q;
   end
   assign high_pin_i = (~high_pin_oe_n_o & high_pin_o) | (high_pin_oe_n_o & ((far_en_i & far_level_i) | (~far_en_i & float_q)));
endmodule : high_pin_far_end

// ===== testbench/tb_top.sv
// Self-checking bench for the pin port block: register tasks plus pin comparisons.
// Assumes the far-end pin model and the bound checker.
`timescale 1ns/100ps
module tb_top;
   localparam logic [31:0] A_SF = ext_bus_port_pkg::STROBE_FSEL_ADDR;
   localparam logic [31:0] A_HF = ext_bus_port_pkg::HIGH_ADDR_FSEL_ADDR;
   localparam logic [31:0] A_HD = ext_bus_port_pkg::HIGH_ADDR_DIR_ADDR;
   localparam logic [31:0] A_HP = ext_bus_port_pkg::HIGH_ADDR_DATA_ADDR;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   ext_bus_port_pkg::reg_req_t req = '0;
   ext_bus_port_pkg::bus_strobe_t bus_stb = 4'b0110, stb_data = 4'b1010, stb_dir = 4'b0100, spin, soen, salt;
   logic [7:0] rd_data, hpin_in, hpin_out, hpin_oen, addr_hi = 8'h00, far_lvl = 8'h00, far_en = 8'h00;
   int mismatches = 0;
   int tests_run = 0;
   always #25 core_clk_i = ~core_clk_i;
   external_bus_pin_ports #(.HIGH_PINS(8)) i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_req_i(req),
      .rd_data_o(rd_data), .address_bus_high_i(addr_hi), .bus_strobe_i(bus_stb), .strobe_port_data_i(stb_data),
      .strobe_port_dir_i(stb_dir), .strobe_pin_o(spin), .strobe_pin_oe_n_o(soen), .strobe_pin_alt_o(salt),
      .high_pin_i(hpin_in), .high_pin_o(hpin_out), .high_pin_oe_n_o(hpin_oen));
   high_pin_far_end i_far (.core_clk_i(core_clk_i), .high_pin_o(hpin_out), .high_pin_oe_n_o(hpin_oen),
      .far_level_i(far_lvl), .far_en_i(far_en), .high_pin_i(hpin_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [7:0] m);
      @(posedge core_clk_i);
      req <= '{addr: a, wdata: d, bit_mask: m, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_i);
      req.wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [7:0] exp);
      @(posedge core_clk_i);
      req <= '{addr: a, wdata: 8'h00, bit_mask: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_i);
      req.rd <= 1'b0;
      #1;
      chk(rd_data, exp);
   endtask : rd
   task automatic give_verdict();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #100_000;
      mismatches++;
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rd(A_SF, 8'h00);
      rd(A_HF, 8'h00);
      wr(A_SF, 8'hFF, 8'hFF);
      rd(A_SF, 8'h53);
      chk({4'h0, spin}, 8'h06);
      @(posedge core_clk_i);
      bus_stb <= 4'b1001;
      wr(A_SF, 8'h00, 8'h10);
      rd(A_SF, 8'h43);
      chk({4'h0, salt}, 8'h0B);
      chk({4'h0, spin & 4'b1011}, 8'h09);
      chk({4'h0, soen}, 8'h04);
      wr(A_HD, 8'h00, 8'hFF);
      wr(A_HP, 8'hA5, 8'hFF);
      chk(hpin_out, 8'hA5);
      chk(hpin_oen, 8'h00);
      rd(A_HP, 8'hA5);
      wr(A_HP, 8'h00, 8'h01);
      rd(A_HP, 8'hA4);
      wr(A_HD, 8'hF0, 8'hFF);
      chk(hpin_oen, 8'hF0);
      @(posedge core_clk_i);
      far_en <= 8'hF0;
      far_lvl <= 8'h3C;
      wr(A_HP, 8'hFF, 8'hFF);
      repeat (5) @(posedge core_clk_i);
      rd(A_HP, 8'h3F);
      @(posedge core_clk_i);
      far_en <= 8'h00;
      wr(A_HD, 8'h00, 8'hFF);
      chk(hpin_out, 8'hFF);
      @(posedge core_clk_i);
      addr_hi <= 8'h5A;
      wr(A_HF, 8'hC3, 8'hFF);
      wr(A_HD, 8'hFF, 8'hFF);
      chk(hpin_out & 8'hC3, 8'h42);
      chk(hpin_oen, 8'h3C);
      rd(A_HF, 8'hC3);
      wr(32'hFFFF_F007, 8'hFF, 8'hFF);
      rd(32'hFFFF_F007, 8'h00);
      wr(A_SF, 8'h00, 8'hFF);
      chk({4'h0, spin & 4'b1011}, 8'h0A);
      give_verdict();
   end
endmodule : tb_top
